/* design/swc_pkg.sv */
// Constants shared by both ends of the selective-wake configuration link.
// Assumes a 16-bit serial frame: rw bit, 7-bit address, 8-bit data.
package swc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;
  localparam int RW_POS = 15;
  localparam int ID_BITS = 29;
  localparam int STD_LSB = 18;
  // Register offsets on the serial link
  localparam logic [6:0] OFS_CTRL = 7'h20;
  localparam logic [6:0] OFS_QUANTA_PER_BIT = 7'h21;
  localparam logic [6:0] OFS_SP = 7'h22;
  localparam logic [6:0] OFS_ID3 = 7'h23;
  localparam logic [6:0] OFS_ID2 = 7'h24;
  localparam logic [6:0] OFS_ID1 = 7'h25;
  localparam logic [6:0] OFS_ID0 = 7'h26;
  localparam logic [6:0] OFS_MASK3 = 7'h27;
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_QUANTA_PER_BIT = 8'hA0;
  localparam logic [7:0] RST_SP = 8'h33;
  localparam logic [7:0] RST_ID = 8'h00;
  localparam logic [7:0] WMASK_CTRL = 8'hF1;
  localparam logic [7:0] WMASK_SP = 8'h3F;
  localparam logic [7:0] WMASK_ID0 = 8'h7F;
  // Control and ID0 field positions
  localparam int CAL_POS = 7;
  localparam int UNLOCK_HI = 6;
  localparam int UNLOCK_LO = 5;
  localparam logic [1:0] UNLOCK_KEY = 2'h3;
  localparam int GATE_POS = 4;
  localparam int VALID_POS = 0;
  localparam int RTR_POS = 1;
  localparam int IDE_POS = 0;
  // Host command port (Wishbone byte addresses)
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam int BUSY_POS = 0;
  localparam int RBYTE_LSB = 8;
endpackage : swc_pkg

/* design/swc_link_if.sv */
// Serial link between host and device ends.
// Assumes the bench instantiates it and joins both ends; no clocking here.
interface swc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Undriven line reads low; no pull modelled
  assign miso = miso_oe & miso_o;
  modport device (input sclk, input cs_n, input mosi, output miso_o,
    output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : swc_link_if

/* design/swc_device.sv */
// Device end: serial register slave, wake configuration and frame match.
// Assumes link pins and the transmit pin are asynchronous to clock; frame
// decoder inputs (rx_*) and mode inputs come from logic on clock.
//
// The implementer's own choice: the Wishbone slave port.
module swc_device (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic stop_mode,
  input wire logic wake_event,
  input wire logic bus_timeout_event,
  input wire logic wake_enabled,
  input wire logic flag_clear,
  input wire logic transceiver_transmit_input,
  input wire logic rx_valid,
  input wire logic [swc_pkg::ID_BITS-1:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [3:0] cfg_dlc,
  swc_link_if.device link,
  output logic selective_wake_enable,
  output logic oscillator_calibration_active,
  output logic trim_reference,
  output logic wake_option_write_enable,
  output logic bus_timeout_flag,
  output logic timeout_irq,
  output logic [7:0] quanta_per_bit,
  output logic [5:0] sample_point_fraction,
  output logic wake_frame
);
  typedef enum logic [1:0] {
    SWC_IDLE = 2'b01,
    SWC_SHIFT = 2'b10
  } swc_state_e;

  swc_state_e state_reg;
  logic [2:0] sclk_s, cs_s, mosi_s, txd_s;
  logic sclk_f, cs_f, mosi_f, txd_f;
  logic sclk_rise, sclk_fall, cs_fall;
  logic [4:0] cnt_reg;
  logic [swc_pkg::FRAME_BITS-2:0] in_sh;
  logic [7:0] out_sh;
  logic [6:0] addr_reg;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ctrl_reg, quanta_per_bit_reg, sp_reg, id3_reg, id2_reg, id1_reg;
  logic [7:0] id0_reg, mask3_reg;
  logic unlocked;
  logic [swc_pkg::ID_BITS-1:0] cfg_id, cfg_mask, eff_mask;

  // Three-stage capture; a level counts once stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 3'h0;
      txd_s <= 3'h7;
      sclk_f <= 1'b0;
      cs_f <= 1'b1;
      mosi_f <= 1'b0;
      txd_f <= 1'b1;
    end else if (ce) begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      mosi_s <= {mosi_s[1:0], link.mosi};
      txd_s <= {txd_s[1:0], transceiver_transmit_input};
      if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
      if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
      if (mosi_s[1] == mosi_s[2]) mosi_f <= mosi_s[2];
      if (txd_s[1] == txd_s[2]) txd_f <= txd_s[2];
    end
  end

  // Edges of the filtered levels
  assign sclk_rise = (sclk_s[1] == sclk_s[2]) & sclk_s[2] & ~sclk_f;
  assign sclk_fall = (sclk_s[1] == sclk_s[2]) & ~sclk_s[2] & sclk_f;
  assign cs_fall = (cs_s[1] == cs_s[2]) & ~cs_s[2] & cs_f;

  // Read view; reserved bits are zero by construction
  function automatic logic [7:0] rd_byte(input logic [6:0] a,
      input logic [7:0] c, input logic [7:0] t, input logic [7:0] s,
      input logic [7:0] i3, input logic [7:0] i2, input logic [7:0] i1,
      input logic [7:0] i0, input logic [7:0] m3);
    case (a)
      swc_pkg::OFS_CTRL: rd_byte = c & swc_pkg::WMASK_CTRL;
      swc_pkg::OFS_QUANTA_PER_BIT: rd_byte = t;
      swc_pkg::OFS_SP: rd_byte = s & swc_pkg::WMASK_SP;
      swc_pkg::OFS_ID3: rd_byte = i3;
      swc_pkg::OFS_ID2: rd_byte = i2;
      swc_pkg::OFS_ID1: rd_byte = i1;
      swc_pkg::OFS_ID0: rd_byte = i0 & swc_pkg::WMASK_ID0;
      swc_pkg::OFS_MASK3: rd_byte = m3;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // Serial frame engine: sample on rising, shift out on falling
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SWC_IDLE;
      cnt_reg <= 5'h00;
      in_sh <= '0;
      out_sh <= 8'h00;
      addr_reg <= 7'h00;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_stb <= 1'b0;
      case (state_reg)
        SWC_IDLE: begin
          if (cs_fall) begin
            state_reg <= SWC_SHIFT;
            cnt_reg <= 5'h00;
            out_sh <= 8'h00;
          end
        end
        SWC_SHIFT: begin
          if (cs_f) begin
            state_reg <= SWC_IDLE;
          end else if (sclk_rise) begin
            in_sh <= {in_sh[13:0], mosi_f};
            cnt_reg <= cnt_reg + 5'h01;
            // Address complete only after the rw bit and seven more
            if (cnt_reg == 5'(swc_pkg::ADDR_BITS + 1)) begin
              addr_reg <= in_sh[6:0];
              out_sh <= rd_byte(in_sh[6:0], ctrl_reg, quanta_per_bit_reg, sp_reg,
                id3_reg, id2_reg, id1_reg, id0_reg, mask3_reg);
            end
            if (cnt_reg == 5'(swc_pkg::FRAME_BITS - 1)) begin
              wr_stb <= in_sh[swc_pkg::RW_POS-1];
              wr_addr <= addr_reg;
              wr_data <= {in_sh[6:0], mosi_f};
            end
          end else if (sclk_fall && cnt_reg > 5'(swc_pkg::DATA_BITS)) begin
            out_sh <= {out_sh[6:0], 1'b0};
          end
        end
        default: state_reg <= SWC_IDLE;
      endcase
    end
  end

  assign link.miso_o = out_sh[7];
  assign link.miso_oe = ~cs_f;

  // Configuration registers; soft reset reloads, restart keeps contents
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      quanta_per_bit_reg <= swc_pkg::RST_QUANTA_PER_BIT;
      sp_reg <= swc_pkg::RST_SP;
      id3_reg <= swc_pkg::RST_ID;
      id2_reg <= swc_pkg::RST_ID;
      id1_reg <= swc_pkg::RST_ID;
      id0_reg <= swc_pkg::RST_ID;
      mask3_reg <= swc_pkg::RST_ID;
    end else if (ce) begin
      if (soft_reset) begin
        quanta_per_bit_reg <= swc_pkg::RST_QUANTA_PER_BIT;
        sp_reg <= swc_pkg::RST_SP;
        id3_reg <= swc_pkg::RST_ID;
        id2_reg <= swc_pkg::RST_ID;
        id1_reg <= swc_pkg::RST_ID;
        id0_reg <= swc_pkg::RST_ID;
        mask3_reg <= swc_pkg::RST_ID;
      end else if (wr_stb) begin
        case (wr_addr)
          swc_pkg::OFS_QUANTA_PER_BIT: quanta_per_bit_reg <= wr_data;
          swc_pkg::OFS_SP: sp_reg <= wr_data & swc_pkg::WMASK_SP;
          swc_pkg::OFS_ID3: id3_reg <= wr_data;
          swc_pkg::OFS_ID2: id2_reg <= wr_data;
          swc_pkg::OFS_ID1: id1_reg <= wr_data;
          swc_pkg::OFS_ID0: id0_reg <= wr_data & swc_pkg::WMASK_ID0;
          swc_pkg::OFS_MASK3: mask3_reg <= wr_data;
          default: ;
        endcase
      end
    end
  end

  // Control register; host set of valid beats a same-cycle wake clear,
  // but never in stop mode, where any configuration write invalidates
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= swc_pkg::RST_CTRL;
    end else if (ce) begin
      if (soft_reset) begin
        ctrl_reg <= swc_pkg::RST_CTRL;
      end else if (wr_stb && wr_addr == swc_pkg::OFS_CTRL) begin
        ctrl_reg <= wr_data & swc_pkg::WMASK_CTRL;
        if (stop_mode) ctrl_reg[swc_pkg::VALID_POS] <= 1'b0;
      end else if (wr_stb && wr_addr >= swc_pkg::OFS_QUANTA_PER_BIT &&
          wr_addr <= swc_pkg::OFS_MASK3) begin
        ctrl_reg[swc_pkg::VALID_POS] <= 1'b0;
      end else if (wake_event) begin
        ctrl_reg[swc_pkg::VALID_POS] <= 1'b0;
      end
    end
  end

  assign unlocked = ctrl_reg[swc_pkg::UNLOCK_HI:swc_pkg::UNLOCK_LO] ==
    swc_pkg::UNLOCK_KEY;
  assign wake_option_write_enable = unlocked;
  assign selective_wake_enable = ctrl_reg[swc_pkg::VALID_POS];

  // Calibration and trim reference output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oscillator_calibration_active <= 1'b0;
      trim_reference <= 1'b0;
    end else if (ce) begin
      oscillator_calibration_active <= ctrl_reg[swc_pkg::CAL_POS] &
        unlocked;
      trim_reference <= ctrl_reg[swc_pkg::CAL_POS] & unlocked & txd_f;
    end
  end

  // Sticky timeout flag; an event with wake_enabled set beats a same-cycle clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_timeout_flag <= 1'b0;
    end else if (ce) begin
      if (bus_timeout_event && wake_enabled) begin
        bus_timeout_flag <= 1'b1;
      end else if (flag_clear) begin
        bus_timeout_flag <= 1'b0;
      end
    end
  end

  assign timeout_irq = bus_timeout_flag & ctrl_reg[swc_pkg::GATE_POS];
  assign quanta_per_bit = quanta_per_bit_reg;
  assign sample_point_fraction = sp_reg[5:0];

  // Compare set: only the high mask byte lives here, rest compares all
  assign cfg_id = {id3_reg, id2_reg, id1_reg, id0_reg[6:2]};
  assign cfg_mask = {mask3_reg, {(swc_pkg::ID_BITS-8){1'b1}}};
  // Standard format compares only bits 28:18
  assign eff_mask = id0_reg[swc_pkg::IDE_POS] ? cfg_mask :
    (cfg_mask & ({swc_pkg::ID_BITS{1'b1}} << swc_pkg::STD_LSB));

  // Wake frame decision, one-cycle pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_frame <= 1'b0;
    end else if (ce) begin
      wake_frame <= rx_valid && selective_wake_enable &&
        (((rx_id ^ cfg_id) & eff_mask) == '0) &&
        (rx_ide == id0_reg[swc_pkg::IDE_POS]) &&
        (rx_rtr == id0_reg[swc_pkg::RTR_POS]) &&
        (rx_dlc == cfg_dlc);
    end
  end
endmodule : swc_device

/* design/swc_host.sv */
// Host end: Wishbone slave command port driving the serial link master.
// Assumes a classic Wishbone master on clock; the link clock is made here.
module swc_host #(
  parameter int HALF = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  swc_link_if.host link
);
  typedef enum logic [3:0] {
    SWC_H_IDLE = 4'b0001,
    SWC_H_LEAD = 4'b0010,
    SWC_H_LOW = 4'b0100,
    SWC_H_HIGH = 4'b1000
  } swc_hstate_e;

  swc_hstate_e state_reg;
  logic [15:0] tx_sh;
  logic [7:0] rx_sh;
  logic [4:0] bit_reg;
  logic [15:0] div_reg;
  logic [2:0] miso_s;
  logic miso_f;
  logic busy;
  logic start;
  logic half_done;

  assign busy = state_reg != SWC_H_IDLE;
  assign half_done = div_reg == 16'(HALF - 1);
  // Frame accepted only when idle and the low bytes are enabled
  assign start = cyc_i & stb_i & ack_o & we_i & ~busy &
    (adr_i == swc_pkg::HOST_CMD) & (&sel_i[1:0]);

  // Bus answer one cycle after request; unmapped reads zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i && stb_i && !ack_o && adr_i == swc_pkg::HOST_STAT) begin
        dat_o[swc_pkg::BUSY_POS] <= busy;
        dat_o[swc_pkg::RBYTE_LSB +: 8] <= rx_sh;
      end
    end
  end

  // Returned data line, three stages, level once two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      miso_s <= 3'h0;
      miso_f <= 1'b0;
    end else if (ce) begin
      miso_s <= {miso_s[1:0], link.miso};
      if (miso_s[1] == miso_s[2]) miso_f <= miso_s[2];
    end
  end

  // Link master, mode 0: data changes low, sampled at end of high half
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SWC_H_IDLE;
      tx_sh <= 16'h0000;
      rx_sh <= 8'h00;
      bit_reg <= 5'h00;
      div_reg <= 16'h0000;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else if (ce) begin
      div_reg <= half_done ? 16'h0000 : div_reg + 16'h0001;
      case (state_reg)
        SWC_H_IDLE: begin
          div_reg <= 16'h0000;
          if (start) begin
            state_reg <= SWC_H_LEAD;
            tx_sh <= dat_i[15:0];
            link.mosi <= dat_i[swc_pkg::RW_POS];
            link.cs_n <= 1'b0;
            bit_reg <= 5'h00;
          end
        end
        SWC_H_LEAD: begin
          if (half_done) begin
            state_reg <= SWC_H_HIGH;
            link.sclk <= 1'b1;
          end
        end
        SWC_H_HIGH: begin
          if (half_done) begin
            link.sclk <= 1'b0;
            rx_sh <= {rx_sh[6:0], miso_f};
            tx_sh <= {tx_sh[14:0], 1'b0};
            link.mosi <= tx_sh[14];
            bit_reg <= bit_reg + 5'h01;
            state_reg <= SWC_H_LOW;
          end
        end
        SWC_H_LOW: begin
          if (half_done) begin
            if (bit_reg == 5'(swc_pkg::FRAME_BITS)) begin
              // Gap with select high so the device sees frame end
              if (link.cs_n) begin
                state_reg <= SWC_H_IDLE;
              end
              link.cs_n <= 1'b1;
              link.mosi <= 1'b0;
            end else begin
              link.sclk <= 1'b1;
              state_reg <= SWC_H_HIGH;
            end
          end
        end
        default: state_reg <= SWC_H_IDLE;
      endcase
    end
  end
endmodule : swc_host

/* verification/swc_checker.sv */
// Concurrent checks on the serial link and the device status outputs.
// Assumes the bench ties every input by name to the link and device.
module swc_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic wake_event,
  input wire logic bus_timeout_event,
  input wire logic wake_enabled,
  input wire logic selective_wake_enable,
  input wire logic oscillator_calibration_active,
  input wire logic trim_reference,
  input wire logic wake_option_write_enable,
  input wire logic bus_timeout_flag,
  input wire logic timeout_irq,
  input wire logic wake_frame
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Link framing; cs filter delay allows a few cycles of drive
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  a_miso_released: assert property (cs_n [*8] |-> !miso_oe)
    else $error("data line driven while deselected");
  a_cs_idle_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  // Device status relations
  a_irq_needs_flag: assert property (timeout_irq |-> bus_timeout_flag)
    else $error("interrupt without timeout flag");
  a_flag_has_cause: assert property ($rose(bus_timeout_flag) |->
    $past(bus_timeout_event) && $past(wake_enabled))
    else $error("timeout flag set without enabled event");
  a_trim_needs_cal: assert property (!oscillator_calibration_active ##1
    !oscillator_calibration_active |-> !trim_reference)
    else $error("trim reference while calibration off");
  a_cal_needs_key: assert property (oscillator_calibration_active |->
    wake_option_write_enable || $past(wake_option_write_enable))
    else $error("calibration active while locked");
  a_wake_clears_valid: assert property (selective_wake_enable &&
    wake_event && cs_n |=> !selective_wake_enable)
    else $error("valid bit survived wake event");
  a_match_needs_valid: assert property (wake_frame |->
    $past(selective_wake_enable))
    else $error("wake frame while setup invalid");
  c_wake: cover property (wake_frame);
  c_irq: cover property (timeout_irq);
  c_trim: cover property (trim_reference);
endmodule : swc_checker

/* verification/testbench.sv */
// Self-checking bench: Wishbone master drives host, host drives device.
// Assumes the design files are compiled first; link half period of 12.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic soft_reset = 1'h0, stop_mode = 1'h0, wake_event = 1'h0;
  logic bus_timeout_event = 1'h0, wake_enabled = 1'h0, flag_clear = 1'h0;
  logic transceiver_transmit_input = 1'h0, rx_valid = 1'h0;
  logic rx_ide = 1'h0, rx_rtr = 1'h0;
  logic [28:0] rx_id = 29'h0;
  logic [3:0] rx_dlc = 4'h0, cfg_dlc = 4'h0, sel_i = 4'hF;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o;
  logic [7:0] adr_i = 8'h00, quanta_per_bit;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic selective_wake_enable, oscillator_calibration_active;
  logic trim_reference, wake_option_write_enable, bus_timeout_flag;
  logic timeout_irq, wake_frame;
  logic [5:0] sample_point_fraction;
  logic [28:0] wid;
  logic [7:0] rv [8] = '{8'h00, 8'hA0, 8'h33, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] wv [8] = '{8'hFF, 8'h5A, 8'hFF, 8'hA5, 8'h3C, 8'h96,
    8'hFF, 8'hF0};
  logic [7:0] ev [8] = '{8'hF1, 8'h5A, 8'h3F, 8'hA5, 8'h3C, 8'h96,
    8'h7F, 8'hF0};
  int num_errors = 0, compares = 0, cycles = 0;
  swc_link_if link();
  swc_device i_swc_device (.clock, .rstn, .ce(1'h1), .soft_reset,
    .stop_mode, .wake_event, .bus_timeout_event, .wake_enabled,
    .flag_clear, .transceiver_transmit_input, .rx_valid, .rx_id, .rx_ide,
    .rx_rtr, .rx_dlc, .cfg_dlc, .link, .selective_wake_enable,
    .oscillator_calibration_active, .trim_reference,
    .wake_option_write_enable, .bus_timeout_flag, .timeout_irq,
    .quanta_per_bit, .sample_point_fraction, .wake_frame);
  swc_host #(.HALF(12)) i_swc_host (.clock, .rstn, .ce(1'h1), .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .link);
  swc_checker i_swc_checker (.clock, .rstn, .sclk(link.sclk),
    .cs_n(link.cs_n), .miso_oe(link.miso_oe), .wake_event,
    .bus_timeout_event, .wake_enabled, .selective_wake_enable,
    .oscillator_calibration_active, .trim_reference,
    .wake_option_write_enable, .bus_timeout_flag, .timeout_irq,
    .wake_frame);
  // Clock at 4 ns period
  always #2 clock = ~clock;
  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask : bchk
  // One classic cycle; ack sampled at the edge, then released
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clock); while (ack_o !== 1'h1);
    r = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clock);
  endtask : wb
  task automatic idle();
    logic [31:0] r;
    do wb(1'h0, swc_pkg::HOST_STAT, 32'h0, r);
    while (r[swc_pkg::BUSY_POS] !== 1'h0);
  endtask : idle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    idle();
    wb(1'h1, swc_pkg::HOST_CMD, {16'h0, 1'h1, a, d}, r);
    idle();
  endtask : wr
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [31:0] r;
    idle();
    wb(1'h1, swc_pkg::HOST_CMD, {16'h0, 1'h0, a, 8'h00}, r);
    idle();
    wb(1'h0, swc_pkg::HOST_STAT, 32'h0, r);
    chk($sformatf("reg %h", a), e, r[15:8]);
  endtask : rchk
  // Offer one received frame, look at the match pulse after it
  task automatic rx(input logic [28:0] i, input logic e, input logic t,
      input logic [3:0] l, input logic x);
    rx_id <= i;
    rx_ide <= e;
    rx_rtr <= t;
    rx_dlc <= l;
    rx_valid <= 1'h1;
    @(posedge clock);
    rx_valid <= 1'h0;
    #1 bchk("wake_frame", x, wake_frame);
    @(posedge clock);
  endtask : rx
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    for (int i = 0; i < 8; i++) rchk(swc_pkg::OFS_CTRL + 7'(i), rv[i]);
    rchk(7'h30, 8'h00);
    $display("reset values done");
    for (int i = 1; i < 8; i++) begin
      wr(swc_pkg::OFS_CTRL + 7'(i), wv[i]);
      rchk(swc_pkg::OFS_CTRL + 7'(i), ev[i]);
    end
    wr(swc_pkg::OFS_CTRL, wv[0]);
    rchk(swc_pkg::OFS_CTRL, ev[0]);
    bchk("valid", 1'h1, selective_wake_enable);
    chk("quanta", 8'h5A, quanta_per_bit);
    chk("sample", 8'h3F, {2'h0, sample_point_fraction});
    $display("field access done");
    for (int k = 0; k < 4; k++) begin
      wr(swc_pkg::OFS_CTRL, {1'h1, 2'(k), 5'h00});
      bchk("option", k == 3, wake_option_write_enable);
      bchk("cal", k == 3, oscillator_calibration_active);
    end
    transceiver_transmit_input <= 1'h1;
    repeat (8) @(posedge clock);
    bchk("trim", 1'h1, trim_reference);
    wr(swc_pkg::OFS_CTRL, 8'h60);
    bchk("cal", 1'h0, oscillator_calibration_active);
    bchk("trim", 1'h0, trim_reference);
    transceiver_transmit_input <= 1'h0;
    $display("unlock done");
    wr(swc_pkg::OFS_CTRL, 8'h01);
    wr(swc_pkg::OFS_QUANTA_PER_BIT, 8'h5A);
    bchk("valid", 1'h0, selective_wake_enable);
    wr(swc_pkg::OFS_CTRL, 8'h01);
    wake_event <= 1'h1;
    @(posedge clock);
    wake_event <= 1'h0;
    @(posedge clock);
    bchk("valid", 1'h0, selective_wake_enable);
    stop_mode <= 1'h1;
    wr(swc_pkg::OFS_CTRL, 8'h01);
    bchk("valid", 1'h0, selective_wake_enable);
    stop_mode <= 1'h0;
    soft_reset <= 1'h1;
    @(posedge clock);
    soft_reset <= 1'h0;
    @(posedge clock);
    rchk(swc_pkg::OFS_QUANTA_PER_BIT, swc_pkg::RST_QUANTA_PER_BIT);
    $display("valid bit done");
    wr(swc_pkg::OFS_CTRL, 8'h10);
    bus_timeout_event <= 1'h1;
    @(posedge clock);
    bus_timeout_event <= 1'h0;
    wake_enabled <= 1'h1;
    @(posedge clock);
    bchk("flag", 1'h0, bus_timeout_flag);
    bus_timeout_event <= 1'h1;
    @(posedge clock);
    bus_timeout_event <= 1'h0;
    @(posedge clock);
    bchk("flag", 1'h1, bus_timeout_flag);
    bchk("irq", 1'h1, timeout_irq);
    wr(swc_pkg::OFS_CTRL, 8'h00);
    bchk("irq", 1'h0, timeout_irq);
    flag_clear <= 1'h1;
    @(posedge clock);
    flag_clear <= 1'h0;
    @(posedge clock);
    bchk("flag", 1'h0, bus_timeout_flag);
    $display("timeout done");
    wid = {8'hA5, 8'h3C, 8'h96, 5'h15};
    cfg_dlc <= 4'h8;
    // Soft reset above cleared the identifier set; load it again
    wr(swc_pkg::OFS_ID3, 8'hA5);
    wr(swc_pkg::OFS_ID2, 8'h3C);
    wr(swc_pkg::OFS_ID1, 8'h96);
    wr(swc_pkg::OFS_MASK3, 8'hF0);
    wr(swc_pkg::OFS_ID0, 8'h55);
    rx(wid, 1'h1, 1'h0, 4'h8, 1'h0);
    wr(swc_pkg::OFS_CTRL, 8'h01);
    rx(wid, 1'h1, 1'h0, 4'h8, 1'h1);
    rx(wid ^ 29'h00200000, 1'h1, 1'h0, 4'h8, 1'h1);
    rx(wid ^ 29'h10000000, 1'h1, 1'h0, 4'h8, 1'h0);
    rx(wid, 1'h1, 1'h0, 4'h7, 1'h0);
    rx(wid, 1'h1, 1'h1, 4'h8, 1'h0);
    rx(wid, 1'h0, 1'h0, 4'h8, 1'h0);
    wr(swc_pkg::OFS_ID0, 8'h54);
    wr(swc_pkg::OFS_CTRL, 8'h01);
    rx(wid ^ 29'h00000001, 1'h0, 1'h0, 4'h8, 1'h1);
    rx(wid ^ 29'h00040000, 1'h0, 1'h0, 4'h8, 1'h0);
    $display("frame match done");
    complete_run();
  end
endmodule : testbench
